// ===== rtl/smf_regs.svh
// register map, field positions and reset values of the spi master
// assumes registers sit one per 32-bit word, byte address = index * 4
`ifndef SMF_REGS_SVH
`define SMF_REGS_SVH
// register indices
`define SMF_IDX_DATA 8'hb8
`define SMF_IDX_CTRL 8'hb9
`define SMF_IDX_STAT 8'hba
`define SMF_IDX_DIV 8'hbb
// master_control fields
`define SMF_CTRL_IRQ_EN 6
`define SMF_CTRL_CS_SEL 5
`define SMF_CTRL_SS_ACT 4
`define SMF_CTRL_OVF_MSK 3
`define SMF_CTRL_DRN_MSK 2
`define SMF_CTRL_CPOL 1
`define SMF_CTRL_CPHA 0
`define SMF_CTRL_WMASK 8'h7f
// master_status fields
`define SMF_STAT_TX_EMPTY 7
`define SMF_STAT_TX_FULL 6
`define SMF_STAT_RX_EMPTY 5
`define SMF_STAT_RX_FULL 4
`define SMF_STAT_OVF 3
`define SMF_STAT_DRN 2
// reset values
`define SMF_CTRL_RST 8'h08
`define SMF_DIV_RST 8'h03
// last half-period of a byte: 16 clock edges
`define SMF_HALF_LAST 4'hf
`endif

// ===== rtl/smf_pkg.sv
// types and address helper shared by the spi master files
// assumes the constants header is on the include path
package smf_pkg;
   // engine states, gray along idle-load-run-done
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_load = 2'b01,
      st_run = 2'b11,
      st_done = 2'b10
   } smf_state_t;

   // register index to apb byte address
   function automatic logic [9:0] smf_byte_addr(input logic [7:0] idx);
      smf_byte_addr = {idx, 2'b00};
   endfunction : smf_byte_addr
endpackage : smf_pkg

// ===== rtl/smf_fifo.sv
// small fifo with registered read data
// assumes one clock; dout follows the head entry one cycle late
`timescale 1ns/1ps
module smf_fifo
   import smf_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clr,
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic pop,
   // state and data
   output logic [W-1:0] dout,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH]; // storage, no reset needed
   logic [AW:0] wp_q; // write pointer with wrap bit
   logic [AW:0] rp_q; // read pointer with wrap bit

   assign empty = (wp_q == rp_q);
   assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);

   // pointers; clear beats push and pop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (clr) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push && !full) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop && !empty) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end

   // storage write, a push into a full fifo is dropped
   always_ff @(posedge clk) begin
      if (push && !full && !clr) begin
         mem[wp_q[AW-1:0]] <= din;
      end
   end

   // head entry out of a register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
      end else begin
         dout <= mem[rp_q[AW-1:0]];
      end
   end
endmodule : smf_fifo

// ===== rtl/smf_shift.sv
// byte shift engine: clock divider, mode handling, miso synchroniser
// assumes tx_data is valid one cycle after tx_valid rises
`timescale 1ns/1ps
module smf_shift
   import smf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic en,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] div,
   // transmit side
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_pop,
   // receive side
   output logic done,
   output logic [7:0] rx_data,
   output logic idle,
   // serial pins
   input wire logic miso,
   output logic sck,
   output logic mosi
);
   `include "smf_regs.svh"
   smf_state_t st_q; // engine state
   logic [7:0] cnt_q; // half-period counter
   logic [3:0] half_q; // edge count within a byte
   logic [7:0] sh_q; // transmit shift register
   logic [2:0] m_q; // miso synchroniser chain
   logic miso_q; // last level on which second and third agreed
   logic miso_f; // filtered miso, agreed level with no extra flop
   logic tick; // end of a half period

   assign tick = (st_q == st_run) && (cnt_q == div);
   assign tx_pop = (st_q == st_load);
   assign done = (st_q == st_done);
   assign idle = (st_q == st_idle);
   // a fourth flop here would sample one cycle late at divisor 3
   assign miso_f = (m_q[1] == m_q[2]) ? m_q[2] : miso_q;

   // three flops; only the second and third are compared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_q <= 3'h0;
         miso_q <= 1'b0;
      end else begin
         m_q <= {m_q[1:0], miso};
         if (m_q[1] == m_q[2]) begin
            miso_q <= m_q[2];
         end
      end
   end

   // state machine; dropping en aborts at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= st_idle;
      end else if (!en) begin
         st_q <= st_idle; // R9
      end else begin
         case (st_q)
            st_idle: if (tx_valid) st_q <= st_load; // R2
            st_load: st_q <= st_run;
            st_run: if (tick && half_q == `SMF_HALF_LAST) st_q <= st_done;
            st_done: st_q <= st_idle;
            default: st_q <= st_idle;
         endcase
      end
   end

   // divider: each half period lasts div+1 cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         half_q <= 4'h0;
      end else if (st_q != st_run) begin
         cnt_q <= 8'h00;
         half_q <= 4'h0;
      end else if (tick) begin
         cnt_q <= 8'h00; // R19
         half_q <= half_q + 4'h1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // serial clock sits at cpol outside a byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck <= 1'b0;
      end else if (st_q != st_run) begin
         sck <= cpol; // R14
      end else if (tick) begin
         sck <= ~sck;
      end
   end

   // shift and sample; cpha picks which edge of each pair samples
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
         mosi <= 1'b0;
         rx_data <= 8'h00;
      end else if (st_q == st_load) begin
         sh_q <= tx_data;
         if (!cpha) begin
            mosi <= tx_data[7]; // R15
            sh_q <= {tx_data[6:0], 1'b0};
         end
      end else if (tick) begin
         if (half_q[0] != cpha) begin
            mosi <= sh_q[7]; // R15
            sh_q <= {sh_q[6:0], 1'b0};
         end else begin
            rx_data <= {rx_data[6:0], miso_f}; // R3
         end
      end
   end
endmodule : smf_shift

// ===== rtl/smf_top.sv
// apb spi master with write and read fifos and two chip selects
// assumes an apb master on pclk; spi slave on the serial pins
//
// Operation
// (R1) data write pushes one byte, 16 deep
// (R2) active select and data: shift oldest byte
// (R3) every byte sent returns one, appended
// (R4) host writes one dummy per read byte
// (R5) separate 16-deep read fifo, popped on read
// (R6) control bit 6 gates interrupt, flags still set
// (R7) control bit 5 picks chip select output
// (R8) control bit 4 drives select low when 1
// (R9) inactive select clears fifos, engine idle
// (R10) host avoids mode change with select activation
// (R11) control bit 3 masks overflow, resets masked
// (R12) control bit 2 masks drained-idle interrupt
// (R13) bits 1:0 hold cpol and cpha
// (R14) serial clock idles at cpol
// (R15) cpha picks sample edge, cpol inverts
// (R16) status shows fifo empty and full flags
// (R17) status bit 3 overflow, write one clears
// (R18) status bit 2 drained idle, write one clears
// (R19) sck is core over twice divisor plus one
// (R20) full fifo push sets overflow, drops byte
// (R21) irq while enabled and unmasked flag set
`timescale 1ns/1ps
module smf_top
   import smf_pkg::*;
#(
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // spi pins
   output logic sck,
   output logic mosi,
   input wire logic miso,
   output logic chip_select_first_n,
   output logic chip_select_second_n,
   // interrupt
   output logic irq
);
   `include "smf_regs.svh"

   // register state
   logic [7:0] master_control_q; // control register
   logic [7:0] serial_clock_divisor_q; // divisor
   logic ovf_q; // overflow flag
   logic drn_q; // drained idle flag
   logic drn_cond_q; // last drained condition
   logic wait_q; // apb wait state done
   logic [31:0] prdata_q; // read data register

   // apb decode
   logic a_data; // transfer_data_port hit
   logic a_ctrl; // master_control hit
   logic a_stat; // master_status hit
   logic a_div; // divisor hit
   logic mapped; // any register hit
   logic acc; // completing access
   logic wr; // write with low lane
   logic wr_data; // write to data port
   logic rd_data; // read of data port

   // fifo and engine wiring
   logic tx_full; // write fifo full
   logic tx_empty; // write fifo empty
   logic [7:0] tx_dout; // write fifo head
   logic tx_pop; // engine takes head
   logic rx_full; // read fifo full
   logic rx_empty; // read fifo empty
   logic [7:0] rx_dout; // read fifo head
   logic eng_done; // byte finished
   logic eng_idle; // engine idle
   logic [7:0] eng_rx; // received byte

   // control fields
   logic irq_en; // interrupt enable
   logic cs_sel; // select output choice
   logic ss_active; // slave select active
   logic ovf_msk; // overflow mask
   logic drn_msk; // drained idle mask
   logic cpol; // clock polarity
   logic cpha; // clock phase

   // events
   logic ovf_ev; // overflow this cycle
   logic drn_cond; // drained and idle now
   logic drn_ev; // drained condition rose
   logic [7:0] status; // master_status view

   assign irq_en = master_control_q[`SMF_CTRL_IRQ_EN];
   assign cs_sel = master_control_q[`SMF_CTRL_CS_SEL];
   assign ss_active = master_control_q[`SMF_CTRL_SS_ACT];
   assign ovf_msk = master_control_q[`SMF_CTRL_OVF_MSK]; // R11
   assign drn_msk = master_control_q[`SMF_CTRL_DRN_MSK]; // R12
   assign cpol = master_control_q[`SMF_CTRL_CPOL]; // R13
   assign cpha = master_control_q[`SMF_CTRL_CPHA]; // R13

   // address decode by word
   assign a_data = (paddr == smf_byte_addr(`SMF_IDX_DATA));
   assign a_ctrl = (paddr == smf_byte_addr(`SMF_IDX_CTRL));
   assign a_stat = (paddr == smf_byte_addr(`SMF_IDX_STAT));
   assign a_div = (paddr == smf_byte_addr(`SMF_IDX_DIV));
   assign mapped = a_data | a_ctrl | a_stat | a_div;

   // one wait state gives the read fifo head time to settle
   assign acc = psel && penable && wait_q;
   assign wr = acc && pwrite && pstrb[0];
   assign wr_data = wr && a_data;
   assign rd_data = acc && !pwrite && a_data;
   assign pready = wait_q;
   assign pslverr = wait_q && !mapped;
   assign prdata = prdata_q;

   // apb wait state: ready on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= psel && penable && !wait_q;
      end
   end

   // status view
   always_comb begin
      status = 8'h00;
      status[`SMF_STAT_TX_EMPTY] = tx_empty; // R16
      status[`SMF_STAT_TX_FULL] = tx_full; // R16
      status[`SMF_STAT_RX_EMPTY] = rx_empty; // R16
      status[`SMF_STAT_RX_FULL] = rx_full; // R16
      status[`SMF_STAT_OVF] = ovf_q;
      status[`SMF_STAT_DRN] = drn_q;
   end

   // read data captured in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (psel && penable && !wait_q) begin
         if (a_data) begin
            prdata_q <= {24'h0, rx_dout};
         end else if (a_ctrl) begin
            prdata_q <= {24'h0, master_control_q};
         end else if (a_stat) begin
            prdata_q <= {24'h0, status};
         end else if (a_div) begin
            prdata_q <= {24'h0, serial_clock_divisor_q};
         end else begin
            prdata_q <= 32'h0; // unmapped reads zero
         end
      end
   end

   // control register; bit 7 reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_control_q <= `SMF_CTRL_RST; // R11
      end else if (wr && a_ctrl) begin
         master_control_q <= pwdata[7:0] & `SMF_CTRL_WMASK;
      end
   end

   // divisor register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_clock_divisor_q <= `SMF_DIV_RST; // R19
      end else if (wr && a_div) begin
         serial_clock_divisor_q <= pwdata[7:0];
      end
   end

   // overflow on either fifo; the byte itself is lost
   assign ovf_ev = (wr_data && tx_full) || (eng_done && rx_full); // R20

   // overflow flag, a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_q <= 1'b0;
      end else if (ovf_ev) begin
         ovf_q <= 1'b1; // R20
      end else if (wr && a_stat && pwdata[`SMF_STAT_OVF]) begin
         ovf_q <= 1'b0; // R17
      end
   end

   // drained idle sets on the rising edge of the condition,
   // otherwise a clear could never stick while idle
   assign drn_cond = tx_empty && eng_idle;
   assign drn_ev = drn_cond && !drn_cond_q;

   // drained idle flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drn_cond_q <= 1'b1;
         drn_q <= 1'b0;
      end else begin
         drn_cond_q <= drn_cond;
         if (drn_ev) begin
            drn_q <= 1'b1; // R18
         end else if (wr && a_stat && pwdata[`SMF_STAT_DRN]) begin
            drn_q <= 1'b0; // R18
         end
      end
   end

   // interrupt output from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_en && ((ovf_q && !ovf_msk) || (drn_q && !drn_msk)); // R6 R21
      end
   end

   // chip selects; the unselected one stays high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_select_first_n <= 1'b1;
         chip_select_second_n <= 1'b1;
      end else begin
         chip_select_first_n <= !(ss_active && !cs_sel); // R7 R8
         chip_select_second_n <= !(ss_active && cs_sel); // R7 R8
      end
   end

   // write fifo, cleared while select inactive
   smf_fifo #(
      .W(8),
      .DEPTH(DEPTH)
   ) u_tx (
      .clk(pclk),
      .rst_n(presetn),
      .clr(!ss_active), // R9
      .push(wr_data), // R1
      .din(pwdata[7:0]),
      .pop(tx_pop),
      .dout(tx_dout),
      .full(tx_full),
      .empty(tx_empty)
   );

   // read fifo, independent of the write fifo
   smf_fifo #(
      .W(8),
      .DEPTH(DEPTH)
   ) u_rx (
      .clk(pclk),
      .rst_n(presetn),
      .clr(!ss_active), // R9
      .push(eng_done), // R3
      .din(eng_rx),
      .pop(rd_data), // R5
      .dout(rx_dout),
      .full(rx_full),
      .empty(rx_empty)
   );

   // shift engine, held idle while select inactive
   smf_shift u_eng (
      .clk(pclk),
      .rst_n(presetn),
      .en(ss_active), // R9
      .cpol(cpol),
      .cpha(cpha),
      .div(serial_clock_divisor_q),
      .tx_valid(!tx_empty), // R2
      .tx_data(tx_dout),
      .tx_pop(tx_pop),
      .done(eng_done),
      .rx_data(eng_rx),
      .idle(eng_idle),
      .miso(miso),
      .sck(sck),
      .mosi(mosi)
   );

   // helper: cycles since sck last changed
   logic sck_prev_q; // sck one cycle ago
   logic [7:0] hold_q; // cycles at current level
   logic seen_q; // an edge already seen this byte

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_prev_q <= 1'b0;
         hold_q <= 8'h00;
         seen_q <= 1'b0;
      end else begin
         sck_prev_q <= sck;
         hold_q <= (sck != sck_prev_q) ? 8'h00 : hold_q + 8'h01;
         if (eng_idle) begin
            seen_q <= 1'b0;
         end else if (sck != sck_prev_q) begin
            seen_q <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   tx_push_a : assert property ( // R1
      wr_data && !tx_full && ss_active |=> !tx_empty)
      else $error("data write did not reach write fifo");

   eng_start_a : assert property ( // R2
      ss_active && !tx_empty && eng_idle ##1 ss_active |-> ##[0:2] !eng_idle)
      else $error("engine did not start on queued byte");

   rx_append_a : assert property ( // R3
      eng_done && !rx_full && ss_active ##1 ss_active |-> !rx_empty)
      else $error("received byte not appended");

   rx_pop_a : assert property ( // R5
      rd_data && !rx_empty && !eng_done && ss_active |=> $changed(u_rx.rp_q))
      else $error("data read did not pop read fifo");

   irq_gate_a : assert property ( // R6
      !$past(irq_en) |-> !irq)
      else $error("interrupt raised while disabled");

   cs_first_a : assert property ( // R7
      ##1 chip_select_first_n == !($past(ss_active) && !$past(cs_sel)))
      else $error("first chip select wrong");

   cs_second_a : assert property ( // R8
      ##1 chip_select_second_n == !($past(ss_active) && $past(cs_sel)))
      else $error("second chip select wrong");

   idle_clear_a : assert property ( // R9
      !ss_active |=> eng_idle && tx_empty && rx_empty)
      else $error("inactive select left state behind");

   sck_idle_a : assert property ( // R14
      eng_idle && $past(eng_idle) && $stable(cpol) |-> sck == cpol)
      else $error("serial clock not at idle level");

   ovf_set_a : assert property ( // R20
      wr_data && tx_full |=> ovf_q ##1 ovf_q || (wr && a_stat))
      else $error("write overflow not flagged");

   half_rate_a : assert property ( // R19
      !eng_idle && seen_q && (sck != sck_prev_q) && $stable(serial_clock_divisor_q)
      |-> hold_q == serial_clock_divisor_q)
      else $error("serial clock half period wrong");
endmodule : smf_top

// ===== tb/smf_slave.sv
// behavioural spi slave answering 8'h5a plus its byte count
// assumes the master idles sck at cpol before select falls
`timescale 1ns/1ps
module smf_slave
   import smf_pkg::*;
(
   // serial pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic cs_n,
   output logic miso,
   // mode and observation
   input wire logic cpha,
   output logic [7:0] rx_byte,
   output int nbytes
);
   logic [3:0] ecnt; // edges seen in this byte
   logic [7:0] tx_sr; // reply still to send
   logic [7:0] rx_sr; // bits taken from mosi
   logic out_b; // bit on miso while selected

   initial begin
      ecnt = 4'h0;
      nbytes = 0;
      out_b = 1'b0;
      tx_sr = 8'h00;
      rx_sr = 8'h00;
      rx_byte = 8'h00;
   end

   // released line shows no stale value, so invert it
   assign miso = cs_n ? ~out_b : out_b;

   // select falling: first reply bit must be ready for cpha 0
   always @(negedge cs_n) begin
      ecnt = 4'h0;
      tx_sr = 8'h5a + nbytes[7:0];
      out_b = tx_sr[7];
      if (!cpha) begin
         tx_sr = tx_sr << 1;
      end
   end

   // edges counted from idle level, so cpol needs no case of its own
   always @(posedge sck or negedge sck) begin
      if (!cs_n) begin
         if (ecnt[0] == cpha) begin
            // sample edge, msb first
            rx_sr = {rx_sr[6:0], mosi};
            if (ecnt >= 4'd14) begin
               rx_byte = rx_sr;
               nbytes = nbytes + 1;
            end
         end else begin
            // shift edge
            out_b = tx_sr[7];
            tx_sr = tx_sr << 1;
         end
         if (ecnt == 4'hf) begin
            // byte boundary: reload next reply
            tx_sr = 8'h5a + nbytes[7:0];
            if (!cpha) begin
               out_b = tx_sr[7];
               tx_sr = tx_sr << 1;
            end
         end
         ecnt = ecnt + 4'h1;
      end
   end
endmodule : smf_slave

// ===== tb/smf_top_tb.sv
// self-checking bench for the apb spi master with a slave model
// assumes the register header on the include path
`timescale 1ns/1ps
`include "smf_regs.svh"
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED at %0t: %s", $time, msg); end end
module smf_top_tb
   import smf_pkg::*;
;
   localparam logic [9:0] A_DATA = {`SMF_IDX_DATA, 2'b00};
   localparam logic [9:0] A_CTRL = {`SMF_IDX_CTRL, 2'b00};
   localparam logic [9:0] A_STAT = {`SMF_IDX_STAT, 2'b00};
   localparam logic [9:0] A_DIV = {`SMF_IDX_DIV, 2'b00};
   // design ports
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sck, mosi, miso, irq;
   logic chip_select_first_n, chip_select_second_n;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   // bench state
   logic cpha_m; // phase told to the slave
   logic [7:0] rx_byte, div;
   logic sel;
   logic [31:0] seed;
   int nbytes, mismatches, n_tests, i, m;
   logic [7:0] exp_tx[$]; // bytes the slave should see
   logic [32:0] exp_rd[$]; // {pslverr, prdata} per read

   smf_top #(.DEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck), .mosi(mosi),
      .miso(miso), .chip_select_first_n(chip_select_first_n),
      .chip_select_second_n(chip_select_second_n), .irq(irq));

   // the unselected output stays high, so the and is the live select
   smf_slave slv_u (.sck(sck), .mosi(mosi), .cs_n(chip_select_first_n & chip_select_second_n),
      .miso(miso), .cpha(cpha_m), .rx_byte(rx_byte), .nbytes(nbytes));

   // 200 mhz core clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // one apb transfer, request held until pready is seen high
   task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      input logic [32:0] e);
      int k;
      if (!wr) begin
         exp_rd.push_back(e);
      end
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         mismatches++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, {25'h0, e});
   endtask : rd

   // wait for the slave to count n bytes, then let the read fifo land
   task automatic wait_bytes(input int n);
      int k;
      k = 0;
      while (nbytes != n && k < 5000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 5000) begin
         mismatches++;
         test_done();
      end
      repeat (8) @(posedge pclk);
   endtask : wait_bytes

   // read results checked at the completing edge
   always @(posedge pclk) begin
      if ((psel && penable && pready) === 1'b1 && pwrite === 1'b0) begin
         `CHK({pslverr, prdata}, exp_rd.pop_front(), "read data")
      end
   end

   // every byte the slave completes must match the oldest written one
   always @(nbytes) begin
      if (nbytes > 0) begin
         `CHK(rx_byte, exp_tx.pop_front(), "mosi byte")
      end
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      presetn = 1'b0;
      cpha_m = 1'b0;
      seed = 32'h940a;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped word
      rd(A_CTRL, 8'h08);
      rd(A_STAT, 8'ha0);
      rd(A_DIV, 8'h03);
      apb(1'b0, 10'h3fc, 8'h00, {1'b1, 32'h0});
      // every mode, alternating select, one random byte each
      for (m = 0; m < 4; m++) begin
         div = 8'd3 + m[7:0];
         sel = m[0];
         wr(A_DIV, div);
         wr(A_CTRL, {2'b00, sel, 3'b011, m[1:0]});
         cpha_m = m[0];
         repeat (3) @(negedge pclk);
         `CHK(sck, m[1], "sck idle")
         `CHK({chip_select_second_n, chip_select_first_n}, 2'b11, "select idle")
         wr(A_CTRL, {2'b00, sel, 3'b111, m[1:0]});
         repeat (3) @(negedge pclk);
         `CHK({chip_select_second_n, chip_select_first_n}, sel ? 2'b01 : 2'b10, "select")
         seed = lfsr(seed);
         exp_tx.push_back(seed[7:0]);
         wr(A_DATA, seed[7:0]);
         i = 0;
         while (sck === m[1] && i < 100) begin
            @(posedge pclk);
            i++;
         end
         i = 0;
         while (sck !== m[1] && i < 100) begin
            @(posedge pclk);
            i++;
         end
         `CHK(i, div + 1, "half period")
         wait_bytes(m + 1);
         rd(A_DATA, 8'h5a + m[7:0]);
         wr(A_CTRL, {2'b00, sel, 3'b011, m[1:0]});
      end
      // fill past 16: one write lost, later one reply lost
      wr(A_DIV, 8'h07);
      wr(A_STAT, 8'h0c);
      wr(A_CTRL, 8'h44);
      cpha_m = 1'b0;
      wr(A_CTRL, 8'h54);
      for (i = 0; i < 18; i++) begin
         seed = lfsr(seed);
         if (i < 17) begin
            exp_tx.push_back(seed[7:0]);
         end
         wr(A_DATA, seed[7:0]);
      end
      rd(A_STAT, 8'h68);
      repeat (3) @(negedge pclk);
      `CHK(irq, 1'b1, "overflow irq")
      wr(A_STAT, 8'h08);
      wait_bytes(21);
      rd(A_STAT, 8'h9c);
      for (i = 0; i < 16; i++) begin
         rd(A_DATA, 8'h5e + i[7:0]);
      end
      rd(A_STAT, 8'hac);
      wr(A_STAT, 8'h08);
      rd(A_STAT, 8'ha4);
      repeat (3) @(negedge pclk);
      `CHK(irq, 1'b0, "drained masked")
      wr(A_CTRL, 8'h50);
      repeat (3) @(negedge pclk);
      `CHK(irq, 1'b1, "drained irq")
      wr(A_CTRL, 8'h10);
      repeat (3) @(negedge pclk);
      `CHK(irq, 1'b0, "irq gated")
      rd(A_STAT, 8'ha4);
      wr(A_STAT, 8'h04);
      rd(A_STAT, 8'ha0);
      // abort mid-byte: queued byte must not survive reactivation
      wr(A_DATA, 8'h33);
      wr(A_DATA, 8'h34);
      repeat (20) @(posedge pclk);
      wr(A_CTRL, 8'h00);
      repeat (3) @(negedge pclk);
      `CHK(sck, 1'b0, "sck idle after abort")
      wr(A_CTRL, 8'h14);
      repeat (300) @(posedge pclk);
      `CHK(nbytes, 21, "fifo cleared")
      test_done();
   end
endmodule : smf_top_tb
